// File: common/tmc_pkg.sv
// Register map and constants of the 16-bit timer/counter.
package tmc_pkg;
    localparam logic [7:0] TMC_ADDR_CONTROL = 8'h00;
    localparam logic [7:0] TMC_ADDR_COUNT_LO = 8'h04;
    localparam logic [7:0] TMC_ADDR_COUNT_HI = 8'h08;
    localparam logic [7:0] TMC_ADDR_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] TMC_ADDR_IRQ_MASK = 8'h10;
    localparam logic [7:0] TMC_ADDR_SIDE_CTRL = 8'h14;
    localparam logic [7:0] TMC_ADDR_PORT_IN = 8'h18;
    localparam int TMC_BIT_WIDE = 7;
    localparam int TMC_BIT_SEL_HI = 6;
    localparam int TMC_BIT_PS_HI = 5;
    localparam int TMC_BIT_PS_LO = 4;
    localparam int TMC_BIT_SEL_LO = 3;
    localparam int TMC_BIT_NOSYNC = 2;
    localparam int TMC_BIT_CLKSRC = 1;
    localparam int TMC_BIT_ON = 0;
    localparam int TMC_BIT_OVF = 1;
    localparam int TMC_BIT_OSC_EN = 3;
    localparam logic [7:0] TMC_CONTROL_RESET = 8'h00;
    localparam logic [7:0] TMC_MASK_RESET = 8'h00;
    localparam logic [7:0] TMC_SIDE_RESET = 8'h00;
    localparam logic [15:0] TMC_COUNT_RESET = 16'h0000;
    localparam logic [15:0] TMC_COUNT_MAX = 16'hffff;
    localparam logic [3:0] TMC_SPECIAL_TRIGGER_MODE = 4'hb;
    localparam int TMC_INSTR_DIV = 4;
    localparam logic [1:0] TMC_INSTR_LAST = 2'h3;
    localparam logic [1:0] TMC_AXI_OKAY = 2'b00;
    localparam logic [1:0] TMC_AXI_SLVERR = 2'b10;
    localparam int TMC_UNITS = 5;
    typedef enum logic [1:0] {
        TMC_ROUTE_ALL_LOW = 2'b00,
        TMC_ROUTE_UNIT1_LOW = 2'b01,
        TMC_ROUTE_UNIT12_LOW = 2'b10,
        TMC_ROUTE_ALL_HIGH = 2'b11
    } tmc_route_t;
endpackage

// File: rtl/tmc_edge_detect.sv
// Optional two-flop synchroniser and armed rising edge detector.
module tmc_edge_detect
    import tmc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ext_clk,
    input wire logic bypass_sync,
    input wire logic arm_clear,
    output logic rise
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    logic armed_q;
    logic level;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= ext_clk;
            sync_q <= meta_q;
        end
    end

    // In asynchronous mode the pin is used directly without sampling, so an edge lands two cycles earlier.
    assign level = bypass_sync ? ext_clk : sync_q;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            prev_q <= 1'b0;
        end
        else
        begin
            prev_q <= level;
        end
    end

    // A rising edge only counts once a falling edge has been seen.
    always_ff @(posedge core_clk)
    begin
        if (rst || arm_clear)
        begin
            armed_q <= 1'b0;
        end
        else if (prev_q && !level)
        begin
            armed_q <= 1'b1;
        end
    end

    assign rise = armed_q && !prev_q && level;
endmodule // tmc_edge_detect

// File: rtl/tmc_prescaler.sv
// Input clock prescaler dividing count pulses by 1, 2, 4 or 8.
module tmc_prescaler
    import tmc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic tick_in,
    input wire logic [1:0] ratio_sel,
    output logic tick_out
);
    logic [2:0] count_q;
    logic [2:0] last;

    function automatic logic [2:0] ratio_last(input logic [1:0] sel);
        unique case (sel)
            2'b00: ratio_last = 3'h0;
            2'b01: ratio_last = 3'h1;
            2'b10: ratio_last = 3'h3;
            2'b11: ratio_last = 3'h7;
        endcase
    endfunction

    assign last = ratio_last(ratio_sel); // see RULE_03

    always_ff @(posedge core_clk)
    begin
        if (rst || clear)
        begin
            count_q <= 3'h0;
        end
        else if (tick_in)
        begin
            count_q <= (count_q >= last) ? 3'h0 : count_q + 3'h1;
        end
    end

    assign tick_out = tick_in && (count_q >= last);
endmodule // tmc_prescaler

// File: rtl/tmc_timer.sv
// 16-bit timer/counter with AXI4-Lite register slave, overflow interrupt and trigger reset.
// Operation
// RULE_01: Wide access bit seven selects buffered 16-bit access or two byte accesses.
// RULE_02: Select bits six and three route timer pairs to the capture units.
// RULE_03: Prescale field bits five and four divide input by 1, 2, 4 or 8.
// RULE_04: Bit two disables external clock synchronisation; ignored with internal clock.
// RULE_05: Bit one picks instruction clock or rising external edges after a first fall.
// RULE_06: On bit zero enables counting; clearing it stops the counter.
// RULE_07: Enabled low-frequency oscillator forces its two pins to inputs reading zero.
// RULE_08: Wide mode maps high byte to buffer; low byte read loads the buffer.
// RULE_09: Wide mode low byte write also loads counter high byte from buffer.
// RULE_10: Wide mode never reaches the true high byte directly.
// RULE_11: Only low byte writes clear the prescaler; high byte writes do not.
// RULE_12: Counter counts up, wraps from all ones to zero, sets overflow flag.
// RULE_13: Overflow flag raises interrupt only while its enable bit is set.
// RULE_14: Trigger from units one or two in mode 1011 using this timer zeroes it.
// RULE_15: Trigger reset is reliable only with internal clock or synchronised counting.
// RULE_16: A software counter write wins over a same-cycle trigger reset.
// RULE_17: Trigger reset never sets the overflow flag.
// RULE_18: Software enables oscillator and sets clock source to count oscillator edges.
// RULE_19: Narrow mode high byte reads and writes act directly on the counter.
module tmc_timer
    import tmc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_count_clock_pin,
    input wire logic [1:0] osc_pin_in,
    input wire logic [1:0] port_c_direction,
    input wire logic [3:0] unit1_mode,
    input wire logic unit1_trigger,
    input wire logic [3:0] unit2_mode,
    input wire logic unit2_trigger,
    output logic irq,
    output logic [1:0] osc_pin_oe_n,
    output logic [TMC_UNITS-1:0] unit_uses_high_pair
);
    logic [7:0] control_q;
    logic [15:0] count_q;
    logic [7:0] hi_buffer_q;
    logic [7:0] status_q;
    logic [7:0] mask_q;
    logic [7:0] side_q;
    logic [1:0] instr_div_q;
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [31:0] rdata_d;
    logic rd_ok;
    logic wr_fire;
    logic rd_fire;
    logic wr_lo;
    logic wr_hi;
    logic rd_lo;
    logic rd_status;
    logic wide;
    logic on;
    logic ext_sel;
    logic osc_en;
    logic ext_rise;
    logic base_tick;
    logic inc;
    logic trig;
    logic [1:0] port_in_d;

    assign wide = control_q[TMC_BIT_WIDE];
    assign on = control_q[TMC_BIT_ON];
    assign ext_sel = control_q[TMC_BIT_CLKSRC];
    assign osc_en = side_q[TMC_BIT_OSC_EN];

    // Write address and data are taken in either order and held until both are present.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end
        else if (wr_fire)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= TMC_AXI_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q == TMC_ADDR_CONTROL || awaddr_q == TMC_ADDR_COUNT_LO
                || awaddr_q == TMC_ADDR_COUNT_HI || awaddr_q == TMC_ADDR_IRQ_STATUS
                || awaddr_q == TMC_ADDR_IRQ_MASK || awaddr_q == TMC_ADDR_SIDE_CTRL
                || awaddr_q == TMC_ADDR_PORT_IN) ? TMC_AXI_OKAY : TMC_AXI_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Byte lane zero carries every register; other lanes are ignored.
    assign wr_lo = wr_fire && wstrb_q[0] && awaddr_q == TMC_ADDR_COUNT_LO;
    assign wr_hi = wr_fire && wstrb_q[0] && awaddr_q == TMC_ADDR_COUNT_HI;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            control_q <= TMC_CONTROL_RESET;
            mask_q <= TMC_MASK_RESET;
            side_q <= TMC_SIDE_RESET;
        end
        else if (wr_fire && wstrb_q[0])
        begin
            if (awaddr_q == TMC_ADDR_CONTROL)
            begin
                control_q <= wdata_q[7:0];
            end
            if (awaddr_q == TMC_ADDR_IRQ_MASK)
            begin
                mask_q <= wdata_q[7:0] & (8'h01 << TMC_BIT_OVF);
            end
            if (awaddr_q == TMC_ADDR_SIDE_CTRL)
            begin
                side_q <= wdata_q[7:0] & (8'h01 << TMC_BIT_OSC_EN);
            end
        end
    end

    // Instruction cycle is every fourth system clock.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            instr_div_q <= 2'h0;
        end
        else
        begin
            instr_div_q <= instr_div_q + 2'h1;
        end
    end

    tmc_edge_detect u_edge (
        .core_clk(core_clk),
        .rst(rst),
        .ext_clk(ext_count_clock_pin),
        .bypass_sync(control_q[TMC_BIT_NOSYNC]), // see RULE_04
        .arm_clear(!on || !ext_sel),
        .rise(ext_rise)
    );

    assign base_tick = on && (ext_sel ? ext_rise : instr_div_q == TMC_INSTR_LAST); // see RULE_05 RULE_06

    tmc_prescaler u_prescale (
        .core_clk(core_clk),
        .rst(rst),
        .clear(wr_lo), // see RULE_11
        .tick_in(base_tick),
        .ratio_sel(control_q[TMC_BIT_PS_HI:TMC_BIT_PS_LO]),
        .tick_out(inc)
    );

    // Trigger only from units routed here, and never in asynchronous counting.
    assign trig = !(ext_sel && control_q[TMC_BIT_NOSYNC]) && (
        (unit1_trigger && unit1_mode == TMC_SPECIAL_TRIGGER_MODE && unit_uses_high_pair[0])
        || (unit2_trigger && unit2_mode == TMC_SPECIAL_TRIGGER_MODE && unit_uses_high_pair[1])
    ); // see RULE_14 RULE_15

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            count_q <= TMC_COUNT_RESET;
        end
        else if (wr_lo)
        begin
            count_q[7:0] <= wdata_q[7:0];
            if (wide)
            begin
                count_q[15:8] <= hi_buffer_q; // see RULE_09 RULE_16
            end
        end
        else if (wr_hi && !wide)
        begin
            count_q[15:8] <= wdata_q[7:0]; // see RULE_19 RULE_16
        end
        else if (trig)
        begin
            count_q <= TMC_COUNT_RESET; // see RULE_14
        end
        else if (inc)
        begin
            count_q <= count_q + 16'h0001; // see RULE_12
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            hi_buffer_q <= 8'h00;
        end
        else if (wr_hi && wide)
        begin
            hi_buffer_q <= wdata_q[7:0]; // see RULE_10
        end
        else if (rd_lo && wide)
        begin
            hi_buffer_q <= count_q[15:8]; // see RULE_08
        end
    end

    // Overflow only on a counted wrap; the set beats a same-cycle read-clear.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            status_q <= 8'h00;
        end
        else if (inc && !trig && !wr_lo && !(wr_hi && !wide) && count_q == TMC_COUNT_MAX)
        begin
            status_q[TMC_BIT_OVF] <= 1'b1; // see RULE_12 RULE_17
        end
        else if (rd_status)
        begin
            status_q <= 8'h00;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(status_q & mask_q); // see RULE_13
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            osc_pin_oe_n <= 2'b11;
            unit_uses_high_pair <= '0;
        end
        else
        begin
            osc_pin_oe_n <= osc_en ? 2'b11 : port_c_direction; // see RULE_07
            unique case (tmc_route_t'({control_q[TMC_BIT_SEL_HI], control_q[TMC_BIT_SEL_LO]}))
                TMC_ROUTE_ALL_LOW: unit_uses_high_pair <= 5'b00000; // see RULE_02
                TMC_ROUTE_UNIT1_LOW: unit_uses_high_pair <= 5'b11110;
                TMC_ROUTE_UNIT12_LOW: unit_uses_high_pair <= 5'b11100;
                TMC_ROUTE_ALL_HIGH: unit_uses_high_pair <= 5'b11111;
            endcase
        end
    end

    assign port_in_d = osc_en ? 2'b00 : osc_pin_in; // see RULE_07

    // Read channel answers one cycle after the address is taken.
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_lo = rd_fire && s_axi_araddr == TMC_ADDR_COUNT_LO;
    assign rd_status = rd_fire && s_axi_araddr == TMC_ADDR_IRQ_STATUS;

    always_comb
    begin
        rdata_d = 32'h0;
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            TMC_ADDR_CONTROL: rdata_d[7:0] = control_q;
            TMC_ADDR_COUNT_LO: rdata_d[7:0] = count_q[7:0];
            TMC_ADDR_COUNT_HI: rdata_d[7:0] = wide ? hi_buffer_q : count_q[15:8]; // see RULE_01
            TMC_ADDR_IRQ_STATUS: rdata_d[7:0] = status_q;
            TMC_ADDR_IRQ_MASK: rdata_d[7:0] = mask_q;
            TMC_ADDR_SIDE_CTRL: rdata_d[7:0] = side_q;
            TMC_ADDR_PORT_IN: rdata_d[1:0] = port_in_d;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= TMC_AXI_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !rd_fire;
            if (rd_fire)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdata_d;
                s_axi_rresp <= rd_ok ? TMC_AXI_OKAY : TMC_AXI_SLVERR;
            end
            else if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // tmc_timer

// File: verif/tmc_timer_monitor.sv
// Assertions on the timer's bus, reset levels and pins.
module tmc_timer_monitor
    import tmc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] port_c_direction,
    input wire logic irq,
    input wire logic [1:0] osc_pin_oe_n,
    input wire logic [TMC_UNITS-1:0] unit_uses_high_pair
);
    logic [7:0] aw_addr_q;
    logic [7:0] ar_addr_q;
    function automatic logic [1:0] resp_of(input logic [7:0] a);
        return (a <= TMC_ADDR_PORT_IN && a[1:0] == 2'h0) ? TMC_AXI_OKAY : TMC_AXI_SLVERR;
    endfunction
    always_ff @(posedge core_clk)
    begin
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_addr_q <= s_axi_awaddr;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            ar_addr_q <= s_axi_araddr;
        end
    end
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    sequence s_aw_taken;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence s_w_taken;
        s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property ((s_aw_taken and s_w_taken) |-> ##[1:3] s_axi_bvalid)
        else $error("no bvalid");
    a_read_answer: assert property (s_ar_taken |-> ##[1:2] s_axi_rvalid)
        else $error("no rvalid");
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bvalid dropped");
    a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rvalid dropped");
    a_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp == resp_of(aw_addr_q))
        else $error("bad bresp");
    a_rresp_code: assert property (s_axi_rvalid |-> s_axi_rresp == resp_of(ar_addr_q))
        else $error("bad rresp");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_reset_levels: assert property (@(posedge core_clk) disable iff (1'h0)
        rst |=> osc_pin_oe_n == 2'h3 && !irq && unit_uses_high_pair == 5'h00)
        else $error("bad reset level");
    a_route_legal: assert property (unit_uses_high_pair inside {5'h00, 5'h1c, 5'h1e, 5'h1f})
        else $error("bad routing");
    a_pins_follow: assert property (osc_pin_oe_n == 2'h3 || osc_pin_oe_n == $past(port_c_direction))
        else $error("pin direction wrong");
endmodule // tmc_timer_monitor

bind tmc_timer tmc_timer_monitor tmc_timer_monitor_inst (
    .core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .port_c_direction, .irq, .osc_pin_oe_n, .unit_uses_high_pair
);

// File: verif/tmc_far_side.sv
// Model of the external count clock and compare units one and two.
module tmc_far_side
(
    input wire logic core_clk,
    output logic ext_pin,
    output logic [3:0] unit1_mode,
    output logic unit1_trigger,
    output logic [3:0] unit2_mode,
    output logic unit2_trigger
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        ext_pin = 1'h1;
        unit1_mode = 4'h0;
        unit1_trigger = 1'h0;
        unit2_mode = 4'h0;
        unit2_trigger = 1'h0;
    end
    // Idle high: a train starts with a fall, so all n rises count.
    task automatic pulse_train(input int n, input int half);
        repeat (n)
        begin
            ext_pin <= 1'h0;
            repeat (half) @(posedge core_clk);
            ext_pin <= 1'h1;
            repeat (half) @(posedge core_clk);
        end
    endtask
    // Sets one unit's mode and pulses its trigger for a cycle.
    task automatic fire(input int unit, input logic [3:0] mode);
        unit1_mode <= (unit == 1) ? mode : 4'h0;
        unit2_mode <= (unit == 2) ? mode : 4'h0;
        @(posedge core_clk);
        unit1_trigger <= (unit == 1);
        unit2_trigger <= (unit == 2);
        @(posedge core_clk);
        unit1_trigger <= 1'h0;
        unit2_trigger <= 1'h0;
    endtask
endmodule // tmc_far_side

// File: verif/tb_tmc_timer.sv
// Self-checking bench of the timer.
module tb_tmc_timer
    import tmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'h0, rst = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [1:0] osc_pin_in = 2'h0, port_c_direction = 2'h3;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, osc_pin_oe_n, resp;
    logic [31:0] s_axi_rdata, got;
    logic [3:0] unit1_mode, unit2_mode;
    logic ext_count_clock_pin, unit1_trigger, unit2_trigger;
    logic [TMC_UNITS-1:0] unit_uses_high_pair;
    logic [15:0] rnd;
    integer seed = 32'h0db1e5e4;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;
    int t_on;
    int span;

    tmc_timer tmc_timer_inst (
        .core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_count_clock_pin, .osc_pin_in,
        .port_c_direction, .unit1_mode, .unit1_trigger, .unit2_mode, .unit2_trigger,
        .irq, .osc_pin_oe_n, .unit_uses_high_pair
    );
    tmc_far_side tmc_far_side_inst (
        .core_clk, .ext_pin(ext_count_clock_pin), .unit1_mode, .unit1_trigger,
        .unit2_mode, .unit2_trigger
    );

    always #5 core_clk = !core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    task automatic summarize();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Window counts may be off by one.
    task automatic check_near(input logic [31:0] g, input int e);
        num_checks++;
        if ($isunknown(g) || int'(g) < e - 1 || int'(g) > e + 1)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_ok = 1'h0;
        logic w_ok = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge core_clk);
            aw_ok = aw_ok || s_axi_awready === 1'h1;
            w_ok = w_ok || s_axi_wready === 1'h1;
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
        end
        while (s_axi_bvalid !== 1'h1) @(posedge core_clk);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge core_clk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'h1);
        got = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge core_clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        check(got, e);
    endtask
    task automatic trig(input logic [7:0] ctl, input int unit, input logic [3:0] mode,
                        input logic [7:0] e);
        wr(TMC_ADDR_CONTROL, ctl & 8'hfe);
        wr(TMC_ADDR_COUNT_HI, 8'h80);
        wr(TMC_ADDR_COUNT_LO, 8'h00);
        wr(TMC_ADDR_CONTROL, ctl);
        tmc_far_side_inst.fire(unit, mode);
        wr(TMC_ADDR_CONTROL, ctl & 8'hfe);
        rdc(TMC_ADDR_COUNT_HI, {24'h0, e});
    endtask
    function automatic logic [4:0] route_model(input int code);
        case (code)
            3: return 5'h1f;
            2: return 5'h1c;
            1: return 5'h1e;
            default: return 5'h00;
        endcase
    endfunction

    initial
    begin
        repeat (8) @(posedge core_clk);
        rst <= 1'h0;
        repeat (2) @(posedge core_clk);
        rdc(TMC_ADDR_CONTROL, 32'h0);
        rdc(TMC_ADDR_IRQ_MASK, 32'h0);
        rd(8'h1c);
        check(resp, TMC_AXI_SLVERR);
        wr(8'h20, 8'h5a);
        check(resp, TMC_AXI_SLVERR);
        for (int i = 0; i < 4; i++)
        begin
            wr(TMC_ADDR_CONTROL, {1'h0, i[1], 2'h0, i[0], 3'h0});
            rdc(TMC_ADDR_CONTROL, {25'h0, i[1], 2'h0, i[0], 3'h0});
            check(unit_uses_high_pair, route_model(i));
        end
        rnd = 16'($random(seed)) | 16'h0100;
        wr(TMC_ADDR_CONTROL, 8'h00);
        wr(TMC_ADDR_COUNT_HI, 8'h34);
        rdc(TMC_ADDR_COUNT_HI, 32'h34);
        wr(TMC_ADDR_CONTROL, 8'h80);
        wr(TMC_ADDR_COUNT_HI, rnd[15:8]);
        rdc(TMC_ADDR_COUNT_HI, {24'h0, rnd[15:8]});
        wr(TMC_ADDR_CONTROL, 8'h00);
        rdc(TMC_ADDR_COUNT_HI, 32'h34);
        wr(TMC_ADDR_CONTROL, 8'h80);
        wr(TMC_ADDR_COUNT_LO, rnd[7:0]);
        wr(TMC_ADDR_CONTROL, 8'h00);
        rdc(TMC_ADDR_COUNT_HI, {24'h0, rnd[15:8]});
        rdc(TMC_ADDR_COUNT_LO, {24'h0, rnd[7:0]});
        wr(TMC_ADDR_COUNT_HI, 8'h34);
        wr(TMC_ADDR_CONTROL, 8'h80);
        rd(TMC_ADDR_COUNT_LO);
        rdc(TMC_ADDR_COUNT_HI, 32'h34);
        for (int ps = 0; ps < 4; ps++)
        begin
            wr(TMC_ADDR_COUNT_HI, 8'h00);
            wr(TMC_ADDR_COUNT_LO, 8'h00);
            wr(TMC_ADDR_CONTROL, {2'h0, ps[1:0], 4'h1});
            t_on = cyc;
            repeat (400) @(posedge core_clk);
            wr(TMC_ADDR_CONTROL, {2'h0, ps[1:0], 4'h0});
            span = cyc - t_on;
            repeat (40) @(posedge core_clk);
            rd(TMC_ADDR_COUNT_LO);
            check_near(got, span / (TMC_INSTR_DIV << ps));
        end
        wr(TMC_ADDR_COUNT_HI, 8'hff);
        wr(TMC_ADDR_COUNT_LO, 8'hfe);
        wr(TMC_ADDR_CONTROL, 8'h01);
        repeat (20) @(posedge core_clk);
        wr(TMC_ADDR_CONTROL, 8'h00);
        check(irq, 1'h0);
        rdc(TMC_ADDR_COUNT_HI, 32'h0);
        wr(TMC_ADDR_IRQ_MASK, 8'h02);
        check(irq, 1'h1);
        rdc(TMC_ADDR_IRQ_STATUS, 32'h2);
        rdc(TMC_ADDR_IRQ_STATUS, 32'h0);
        check(irq, 1'h0);
        trig(8'h49, 1, TMC_SPECIAL_TRIGGER_MODE, 8'h00);
        trig(8'h49, 2, TMC_SPECIAL_TRIGGER_MODE, 8'h00);
        trig(8'h41, 1, TMC_SPECIAL_TRIGGER_MODE, 8'h80);
        trig(8'h49, 2, 4'ha, 8'h80);
        rdc(TMC_ADDR_IRQ_STATUS, 32'h0);
        for (int s = 0; s < 2; s++)
        begin
            wr(TMC_ADDR_COUNT_LO, 8'h00);
            wr(TMC_ADDR_CONTROL, {5'h0, s[0], 2'h3});
            tmc_far_side_inst.pulse_train(5 + s, 4);
            repeat (6) @(posedge core_clk);
            wr(TMC_ADDR_CONTROL, 8'h00);
            rdc(TMC_ADDR_COUNT_LO, 5 + s);
        end
        osc_pin_in <= 2'($random(seed));
        port_c_direction <= 2'($random(seed));
        wr(TMC_ADDR_SIDE_CTRL, 8'h08);
        check(osc_pin_oe_n, 2'h3);
        rdc(TMC_ADDR_PORT_IN, 32'h0);
        wr(TMC_ADDR_SIDE_CTRL, 8'h00);
        rd(TMC_ADDR_PORT_IN);
        check(got, {30'h0, osc_pin_in});
        check(osc_pin_oe_n, port_c_direction);
        summarize();
    end

    // The tests take about 2200 cycles; this allows 10000.
    initial
    begin
        #100us;
        miscompares++;
        summarize();
    end
endmodule // tb_tmc_timer
